// ===== dpx_pkg.sv
// package: port decode, field layout and carrier types of the dma page address extender
package dpx_pkg;
    // ==========================================================
    // i/o port decode
    localparam int         DPX_IO_AW     = 16;
    localparam logic [15:0] DPX_PORT_CH0 = 16'h0087;
    localparam logic [15:0] DPX_PORT_CH1 = 16'h0083;
    localparam logic [15:0] DPX_PORT_CH2 = 16'h0081;
    localparam logic [15:0] DPX_PORT_CH3 = 16'h0082;
    localparam logic [15:0] DPX_PORT_CH5 = 16'h008b;
    localparam logic [15:0] DPX_PORT_CH6 = 16'h0089;
    localparam logic [15:0] DPX_PORT_CH7 = 16'h008a;
    localparam logic [15:0] DPX_PORT_RFSH = 16'h008f;

    // ==========================================================
    // page file slots
    localparam int         DPX_SLOTS     = 8;
    localparam logic [2:0] DPX_SLOT_CH0  = 3'h0;
    localparam logic [2:0] DPX_SLOT_CH1  = 3'h1;
    localparam logic [2:0] DPX_SLOT_CH2  = 3'h2;
    localparam logic [2:0] DPX_SLOT_CH3  = 3'h3;
    localparam logic [2:0] DPX_SLOT_RFSH = 3'h4;
    localparam logic [2:0] DPX_SLOT_CH5  = 3'h5;
    localparam logic [2:0] DPX_SLOT_CH6  = 3'h6;
    localparam logic [2:0] DPX_SLOT_CH7  = 3'h7;
    localparam logic [7:0] DPX_PAGE_RST  = 8'h00;

    // ==========================================================
    // address layout
    localparam int DPX_SYS_AW   = 24;
    localparam int DPX_LOW_AW   = 16;
    localparam int DPX_BYTE_PG  = 16;
    localparam int DPX_WORD_PG  = 17;

    typedef enum logic [1:0] {
        DPX_CYC_IDLE,
        DPX_CYC_DMA,
        DPX_CYC_RFSH
    } dpx_cyc_e;

    // host i/o request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } dpx_io_s;

    // dma controller address request
    typedef struct packed {
        logic        dma;
        logic        rfsh;
        logic [2:0]  chan;
        logic [15:0] low;
    } dpx_dma_s;

    // system address out
    typedef struct packed {
        logic        valid;
        logic [23:0] addr;
        logic        upper_byte_enable;
    } dpx_sys_s;
endpackage

// ===== dpx_page_ram.sv
// page register file: eight byte slots, two registered read ports
`timescale 1ns/100ps
module dpx_page_ram #(
    parameter int DW = 8,
    parameter int N  = 8
) (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    // write port
    input  wire logic                 wr_en,
    input  wire logic [$clog2(N)-1:0] wr_slot,
    input  wire logic [DW-1:0]        wr_data,
    // read port A, host
    input  wire logic [$clog2(N)-1:0] rd_slot_a,
    output logic      [DW-1:0]        rd_data_a,
    // read port B, address path
    input  wire logic [$clog2(N)-1:0] rd_slot_b,
    output logic      [DW-1:0]        rd_data_b
);
    logic [DW-1:0] mem [N];
    logic [DW-1:0] next_mem [N];

    always_comb begin
        for (int i = 0; i < N; i++) begin
            next_mem[i] = mem[i];
        end
        if (wr_en) begin
            next_mem[wr_slot] = wr_data;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < N; i++) begin
                mem[i] <= '0;
            end
            rd_data_a <= '0;
            rd_data_b <= '0;
        end else begin
            mem       <= next_mem;
            rd_data_a <= mem[rd_slot_a];
            rd_data_b <= mem[rd_slot_b];
        end
    end
endmodule

// ===== dpx_top.sv
// top of the dma page address extender: i/o decode and 24-bit address forming
//
// Function
// - byte channels: page to a23-a16, low a15-a0
// - byte channels: upper byte enable is not a0
// - word channels: page to a23-a17, low shifted
// - word channels: upper_byte_enable held 0, a0 zero
// - no carry into page; wrap 64k/128k
// - ports 87,83,81,82 for channels 0-3
// - ports 8b,89,8a for channels 5-7
// - refresh page at 8f for refresh cycles
// - channel 4 cascade: no page, no address
// - byte channels reach full 16mb space
// - word channels even addresses, 16-bit only
`timescale 1ns/100ps
module dpx_top
    import dpx_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // host i/o
    input  wire dpx_pkg::dpx_io_s  io_req,
    output logic      [7:0]        io_rdata,
    output logic                   io_rvalid,
    output logic                   io_hit,
    // dma controllers
    input  wire dpx_pkg::dpx_dma_s dma_req,
    // system address
    output dpx_pkg::dpx_sys_s      sys_out
);
    import dpx_pkg::*;

    // ==========================================================
    // port decode: one comparator per page slot, table in page file order
    localparam logic [DPX_SLOTS-1:0][15:0] SLOT_PORT = {
        DPX_PORT_CH7,
        DPX_PORT_CH6,
        DPX_PORT_CH5,
        DPX_PORT_RFSH,
        DPX_PORT_CH3,
        DPX_PORT_CH2,
        DPX_PORT_CH1,
        DPX_PORT_CH0
    };

    logic [DPX_SLOTS-1:0] slot_hit;
    logic                 hit;
    logic [2:0]           slot;

    // full 16-bit compare: aliases in the upper port bits stay silent
    for (genvar k = 0; k < DPX_SLOTS; k++) begin : g_decode
        assign slot_hit[k] = (io_req.addr == SLOT_PORT[k]);
    end

    always_comb begin
        hit  = |slot_hit;
        slot = DPX_SLOT_CH0;
        for (int k = 0; k < DPX_SLOTS; k++) begin
            if (slot_hit[k]) begin
                slot = 3'(k);
            end
        end
    end

    // ==========================================================
    // page storage; channel 4 has no slot, its code reuses slot 4 for refresh only
    logic       wr_en;
    logic [7:0] host_page;
    logic [7:0] dma_page;
    logic [2:0] dma_slot;

    assign wr_en    = io_req.wr & hit;
    assign dma_slot = dma_req.rfsh ? DPX_SLOT_RFSH : dma_req.chan;

    dpx_page_ram #(
        .DW (8),
        .N  (DPX_SLOTS)
    ) u_page (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .wr_en     (wr_en),
        .wr_slot   (slot),
        .wr_data   (io_req.wdata),
        .rd_slot_a (slot),
        .rd_data_a (host_page),
        .rd_slot_b (dma_slot),
        .rd_data_b (dma_page)
    );

    // ==========================================================
    // host read return: two cycles after the read strobe
    logic rd_q;
    logic hit_q;
    logic next_rd_q;
    logic next_hit_q;
    logic [7:0] next_io_rdata;
    logic next_io_rvalid;
    logic next_io_hit;

    always_comb begin
        next_rd_q      = io_req.rd & hit;
        next_hit_q     = hit & (io_req.rd | io_req.wr);
        next_io_rvalid = rd_q;
        next_io_hit    = hit_q;
        next_io_rdata  = rd_q ? host_page : 8'h00;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_q      <= 1'b0;
            hit_q     <= 1'b0;
            io_rvalid <= 1'b0;
            io_hit    <= 1'b0;
            io_rdata  <= 8'h00;
        end else begin
            rd_q      <= next_rd_q;
            hit_q     <= next_hit_q;
            io_rvalid <= next_io_rvalid;
            io_hit    <= next_io_hit;
            io_rdata  <= next_io_rdata;
        end
    end

    // ==========================================================
    // address path; stage 1 matches the ram read latency
    dpx_cyc_e    cyc_q;
    dpx_cyc_e    next_cyc_q;
    logic [2:0]  chan_q;
    logic [2:0]  next_chan_q;
    logic [15:0] low_q;
    logic [15:0] next_low_q;
    dpx_sys_s    next_sys;

    always_comb begin
        next_cyc_q  = DPX_CYC_IDLE;
        next_chan_q = dma_req.chan;
        next_low_q  = dma_req.low;
        if (dma_req.rfsh) begin
            next_cyc_q = DPX_CYC_RFSH;
        end else if (dma_req.dma && dma_req.chan != 3'h4) begin
            next_cyc_q = DPX_CYC_DMA;
        end
    end

    // page and low part are only concatenated, never summed, so no carry crosses
    always_comb begin
        next_sys = '0;
        unique case (cyc_q)
            DPX_CYC_IDLE: next_sys = '0;
            DPX_CYC_RFSH: begin
                next_sys.valid = 1'b1;
                next_sys.addr  = {dma_page, low_q};
                next_sys.upper_byte_enable = ~low_q[0];
            end
            DPX_CYC_DMA: begin
                next_sys.valid = 1'b1;
                if (!chan_q[2]) begin
                    next_sys.addr = {dma_page, low_q};
                    next_sys.upper_byte_enable = ~low_q[0];
                end else begin
                    // page bit 0 unused: 128k block
                    next_sys.addr = {dma_page[7:1], low_q, 1'b0};
                    next_sys.upper_byte_enable = 1'b0;
                end
            end
            default: next_sys = '0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cyc_q   <= DPX_CYC_IDLE;
            chan_q  <= 3'h0;
            low_q   <= 16'h0000;
            sys_out <= '0;
        end else begin
            cyc_q   <= next_cyc_q;
            chan_q  <= next_chan_q;
            low_q   <= next_low_q;
            sys_out <= next_sys;
        end
    end
endmodule

// ===== dpx_top_monitor.sv
// assertion checker on the page address extender ports
`timescale 1ns/100ps
module dpx_top_monitor
    import dpx_pkg::*;
(
    // watched ports
    input wire logic              clk_sys,
    input wire logic              reset_n,
    input wire dpx_pkg::dpx_io_s  io_req,
    input wire logic [7:0]        io_rdata,
    input wire logic              io_rvalid,
    input wire logic              io_hit,
    input wire dpx_pkg::dpx_dma_s dma_req,
    input wire dpx_pkg::dpx_sys_s sys_out
);
    // =====
    // request decode
    logic mapped;
    logic byte_cyc;
    logic word_cyc;
    assign mapped = io_req.addr inside {DPX_PORT_CH0, DPX_PORT_CH1, DPX_PORT_CH2, DPX_PORT_CH3,
                                        DPX_PORT_CH5, DPX_PORT_CH6, DPX_PORT_CH7, DPX_PORT_RFSH};
    assign byte_cyc = dma_req.dma && !dma_req.rfsh && dma_req.chan < 3'h4;
    assign word_cyc = dma_req.dma && !dma_req.rfsh && dma_req.chan > 3'h4;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_access;
        io_req.rd || io_req.wr;
    endsequence
    // =====
    // properties
    a_hit_mapped: assert property (s_access ##0 mapped |-> ##2 io_hit) else $error("no hit");
    a_miss_unmapped: assert property (s_access ##0 !mapped |-> ##2 !io_hit && !io_rvalid) else $error("stray hit");
    a_read_return: assert property (io_req.rd && mapped |-> ##2 io_rvalid) else $error("no read data");
    a_rdata_idle: assert property (!io_rvalid |-> io_rdata == 8'h00) else $error("rdata not idle");
    a_byte_form: assert property (byte_cyc |-> ##2 sys_out.valid
        && sys_out.addr[15:0] == $past(dma_req.low, 2)
        && sys_out.upper_byte_enable == !sys_out.addr[0]) else $error("byte address");
    a_word_form: assert property (word_cyc |-> ##2 sys_out.valid && !sys_out.upper_byte_enable
        && sys_out.addr[16:0] == {$past(dma_req.low, 2), 1'b0}) else $error("word address");
    a_cascade_quiet: assert property (!dma_req.rfsh && (!dma_req.dma || dma_req.chan == 3'h4)
        |-> ##2 !sys_out.valid && sys_out.addr == 24'h0) else $error("cascade drove");
    a_refresh_form: assert property (dma_req.rfsh |-> ##2 sys_out.valid
        && sys_out.addr[15:0] == $past(dma_req.low, 2)) else $error("refresh address");
endmodule

bind dpx_top dpx_top_monitor u_monitor (.clk_sys(clk_sys), .reset_n(reset_n), .io_req(io_req),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .io_hit(io_hit), .dma_req(dma_req), .sys_out(sys_out));

// ===== dpx_dma_ctlr.sv
// dma controller stand-in: launches one address request per clock
`timescale 1ns/100ps
module dpx_dma_ctlr
    import dpx_pkg::*;
(
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              reset_n,
    // command in, request out
    input wire dpx_pkg::dpx_dma_s cmd,
    output dpx_pkg::dpx_dma_s     dma_req
);
    dpx_dma_s next_dma_req;
    // =====
    // launch register, as a controller clocks out its address
    always_comb begin
        next_dma_req = cmd;
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dma_req <= '0;
        end else begin
            dma_req <= next_dma_req;
        end
    end
endmodule

// ===== dpx_page_address_extender_tb_top.sv
// testbench: page register access and address forming
`timescale 1ns/100ps
module dpx_page_address_extender_tb_top;
    import dpx_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    dpx_io_s     io_req = '0;
    dpx_dma_s    cmd = '0;
    dpx_dma_s    dma_req;
    dpx_sys_s    sys_out;
    logic [7:0]  io_rdata;
    logic        io_rvalid;
    logic        io_hit;
    int          n_mismatch = 0;
    int          n_compared = 0;
    logic [7:0]  pg [8];
    logic [15:0] port [8] = '{DPX_PORT_CH0, DPX_PORT_CH1, DPX_PORT_CH2, DPX_PORT_CH3,
                              DPX_PORT_RFSH, DPX_PORT_CH5, DPX_PORT_CH6, DPX_PORT_CH7};
    always #4 clk_sys = ~clk_sys;
    dpx_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .io_req(io_req), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid), .io_hit(io_hit), .dma_req(dma_req), .sys_out(sys_out));
    dpx_dma_ctlr u_ctlr (.clk_sys(clk_sys), .reset_n(reset_n), .cmd(cmd), .dma_req(dma_req));
    // =====
    // access tasks
    task tick;
        @(posedge clk_sys);
        #1;
    endtask
    task chk(input string n, input logic [23:0] e, input logic [23:0] s);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // d is write data, or expected data on a read
    task io(input logic r, input logic w, input logic [15:0] a, input logic [7:0] d, input logic h);
        io_req = {r, w, a, d};
        tick;
        io_req = '0;
        tick;
        chk("io_hit", h, io_hit);
        chk("io_rvalid", r & h, io_rvalid);
        chk("io_rdata", (r & h) ? d : 8'h00, io_rdata);
    endtask
    // controller register adds one cycle ahead of the two-cycle path
    task dm(input logic d, input logic r, input logic [2:0] c, input logic [15:0] lo, input logic [23:0] ea,
            input logic v);
        cmd = {d, r, c, lo};
        repeat (3) tick;
        chk("sys_out.valid", v, sys_out.valid);
        chk("sys_out.addr", ea, sys_out.addr);
        chk("sys_out.upper_byte_enable", v & ~ea[0] & (r | c < 3'h4), sys_out.upper_byte_enable);
    endtask
    task wrap_up;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // =====
    // main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            pg[i] = 8'h81 + 8'h22 * i[7:0];
            io(1'b1, 1'b0, port[i], 8'h00, 1'b1);
            io(1'b0, 1'b1, port[i], pg[i], 1'b1);
        end
        for (int i = 0; i < 8; i++) io(1'b1, 1'b0, port[i], pg[i], 1'b1);
        io(1'b0, 1'b1, 16'h0080, 8'hff, 1'b0);
        io(1'b1, 1'b0, 16'h0084, 8'h00, 1'b0);
        io(1'b1, 1'b0, 16'h0187, 8'h00, 1'b0);
        io(1'b1, 1'b0, port[0], pg[0], 1'b1);
        for (int c = 0; c < 4; c++) begin
            dm(1'b1, 1'b0, c[2:0], 16'hffff, {pg[c], 16'hffff}, 1'b1);
            dm(1'b1, 1'b0, c[2:0], 16'h1234, {pg[c], 16'h1234}, 1'b1);
        end
        for (int c = 5; c < 8; c++) dm(1'b1, 1'b0, c[2:0], 16'hffff, {pg[c][7:1], 16'hffff, 1'b0}, 1'b1);
        dm(1'b1, 1'b0, 3'h7, 16'h0000, {pg[7][7:1], 17'h0}, 1'b1);
        dm(1'b1, 1'b0, 3'h4, 16'h5555, 24'h0, 1'b0);
        dm(1'b0, 1'b0, 3'h1, 16'h5555, 24'h0, 1'b0);
        dm(1'b1, 1'b1, 3'h6, 16'h0102, {pg[4], 16'h0102}, 1'b1);
        wrap_up;
    end
endmodule
